// File: verilog/mhbsd_pkg.sv
// constants and types shared by the host bus strobe decoder
package mhbsd_pkg;
   // host bus modes, selected by a static strap
   typedef enum logic [2:0] {
      MHBSD_GENERIC_SPLIT    = 3'h0,
      MHBSD_GENERIC_HIGHBYTE = 3'h1,
      MHBSD_STROBE_START     = 3'h2,
      MHBSD_DUAL_STROBE      = 3'h3,
      MHBSD_SIZED_STROBE     = 3'h4,
      MHBSD_BYTE_LANE_OE     = 3'h5,
      MHBSD_SPLIT_WE         = 3'h6
   } mhbsd_mode_e;

   // access state machine, gray coded along idle -> busy -> done
   typedef enum logic [1:0] {
      MHBSD_IDLE = 2'h0,
      MHBSD_BUSY = 2'h1,
      MHBSD_DONE = 2'h3
   } mhbsd_state_e;

   localparam logic [2:0] MHBSD_MODE_RESET  = 3'h0;
   localparam logic [1:0] MHBSD_SYNC_RESET  = 2'h0;
   localparam int         MHBSD_CLK_HZ      = 50000000;
   // cycles the wait output stays active before the done cycle
   localparam logic [1:0] MHBSD_WAIT_CYCLES = 2'h2;
   localparam int         MHBSD_LANE_LO     = 0;
   localparam int         MHBSD_LANE_HI     = 1;
endpackage

// File: verilog/mhbsd_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module mhbsd_sync #(
   parameter int          WIDTH = 8,
   parameter logic [31:0] INIT  = 32'h0
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT[WIDTH-1:0];
         pin_sync <= INIT[WIDTH-1:0];
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end
endmodule

// File: verilog/mhbsd_top.sv
// host bus strobe decoder: pins to internal byte-lane read/write requests
// Operation
// - address space select high picks display memory
// - cycles accepted only with chip select low
// - generic split: write strobes per byte lane
// - generic split: read strobe low lane, direction low reads high lane
// - generic highbyte: write, high-byte enable, read
// - strobe start: start, two writes, read strobe
// - strobe start: direction decodes cycle early
// - dual strobe: address, upper strobe, direction
// - sized strobe: size bits, single data strobe
// - sized strobe: address strobe and direction
// - byte lane oe: lane enables, output enable
// - byte lane oe: direction high means read
// - split write enable: lane writes, output enable
// - lowest address pin used in three modes
// - wait active, then inactive, then released
// - reset clears registers, sync flops load strobes idle high, outputs inactive
`timescale 1ns/100ps
module mhbsd_top (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] mode_strap,
   input  wire logic       wait_pol_strap,
   input  wire logic       chip_select_n,
   input  wire logic       space_select,
   input  wire logic       bus_start_pin,
   input  wire logic       direction_pin,
   input  wire logic       read_strobe_pin,
   input  wire logic       first_write_strobe_pin,
   input  wire logic       second_write_strobe_pin,
   input  wire logic       address_bit0_pin,
   output logic            req_valid_reg,
   output logic            req_write_reg,
   output logic            req_memory_reg,
   output logic [1:0]      req_lanes_reg,
   output logic [1:0]      req_size_reg,
   output logic            wait_out_reg,
   output logic            wait_oe_n_reg
);
   logic [8:0]                 pins_sync;
   logic                       cs_n_s;
   logic                       mr_s;
   logic                       bs_n_s;
   logic                       dir_s;
   logic                       rd_n_s;
   logic                       we0_n_s;
   logic                       we1_n_s;
   logic                       ab0_s;
   logic                       strap_done_reg;
   logic                       wait_pol_reg;
   mhbsd_pkg::mhbsd_mode_e     mode_reg;
   mhbsd_pkg::mhbsd_state_e    state_reg;
   logic                       early_read_reg;
   logic [1:0]                 wait_cnt_reg;
   logic                       act_rd;
   logic                       act_wr;
   logic [1:0]                 act_lanes;
   logic [1:0]                 act_size;
   logic                       cycle_on;

   // all bus pins cross two flops; strobes idle high
   mhbsd_sync #(
      .WIDTH (9),
      .INIT  (32'h000001fe)
   ) u_sync (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .pin_in   ({chip_select_n, bus_start_pin, direction_pin, read_strobe_pin,
                  first_write_strobe_pin, second_write_strobe_pin, space_select,
                  address_bit0_pin, 1'b0}),
      .pin_sync (pins_sync)
   );
   assign cs_n_s  = pins_sync[8];
   assign bs_n_s  = pins_sync[7];
   assign dir_s   = pins_sync[6];
   assign rd_n_s  = pins_sync[5];
   assign we0_n_s = pins_sync[4];
   assign we1_n_s = pins_sync[3];
   assign mr_s    = pins_sync[2];
   assign ab0_s   = pins_sync[1];

   // lane pair from an address bit: even byte low lane, odd high lane
   function automatic logic [1:0] lane_from_a0(input logic a0);
      lane_from_a0 = a0 ? 2'h2 : 2'h1;
   endfunction

   // straps caught once on the first clock after release, never async
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_reg <= 1'b0;
         mode_reg       <= mhbsd_pkg::mhbsd_mode_e'(mhbsd_pkg::MHBSD_MODE_RESET);
         wait_pol_reg   <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         mode_reg       <= mhbsd_pkg::mhbsd_mode_e'(mode_strap);
         wait_pol_reg   <= wait_pol_strap;
      end
   end

   // early direction capture on the start-of-cycle strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         early_read_reg <= 1'b0;
      end else if (!bs_n_s && !cs_n_s) begin
         early_read_reg <= dir_s;
      end
   end

   // per-mode decode of the strobe pins into a read or write and lanes
   always_comb begin
      act_rd    = 1'b0;
      act_wr    = 1'b0;
      act_lanes = 2'h0;
      act_size  = 2'h0;
      case (mode_reg)
         mhbsd_pkg::MHBSD_GENERIC_SPLIT: begin
            act_wr    = !we0_n_s || !we1_n_s;
            act_rd    = !rd_n_s || !dir_s;
            act_lanes = act_wr ? {!we1_n_s, !we0_n_s} : {!dir_s, !rd_n_s};
         end
         mhbsd_pkg::MHBSD_GENERIC_HIGHBYTE: begin
            act_wr    = !we0_n_s;
            act_rd    = !rd_n_s;
            act_lanes = {!we1_n_s, !ab0_s};
         end
         mhbsd_pkg::MHBSD_STROBE_START: begin
            act_wr    = !early_read_reg && (!we0_n_s || !we1_n_s);
            act_rd    = early_read_reg && !rd_n_s;
            act_lanes = act_rd ? 2'h3 : {!we1_n_s, !we0_n_s};
         end
         mhbsd_pkg::MHBSD_DUAL_STROBE: begin
            act_wr    = !bs_n_s && !dir_s && (!we1_n_s || !ab0_s);
            act_rd    = !bs_n_s && dir_s && (!we1_n_s || !ab0_s);
            act_lanes = {!we1_n_s, !ab0_s};
         end
         mhbsd_pkg::MHBSD_SIZED_STROBE: begin
            act_size  = {rd_n_s, we0_n_s};
            act_wr    = !bs_n_s && !we1_n_s && !dir_s;
            act_rd    = !bs_n_s && !we1_n_s && dir_s;
            // size 1 picks a lane by address bit 0, otherwise both
            act_lanes = (act_size == 2'h1) ? lane_from_a0(ab0_s) : 2'h3;
         end
         mhbsd_pkg::MHBSD_BYTE_LANE_OE: begin
            act_wr    = !dir_s && (!we0_n_s || !we1_n_s);
            act_rd    = dir_s && !rd_n_s;
            act_lanes = {!we1_n_s, !we0_n_s};
         end
         mhbsd_pkg::MHBSD_SPLIT_WE: begin
            act_wr    = !we0_n_s || !we1_n_s;
            act_rd    = rd_n_s ? 1'b0 : !act_wr;
            act_lanes = act_wr ? {!we1_n_s, !we0_n_s} : 2'h3;
         end
         default: begin
            act_rd    = 1'b0;
            act_wr    = 1'b0;
            act_lanes = 2'h0;
            act_size  = 2'h0;
         end
      endcase
   end

   // a request needs chip select, a decoded cycle and at least one lane
   assign cycle_on = strap_done_reg && !cs_n_s && (act_rd || act_wr) && (act_lanes != 2'h0);

   // access sequencer: one request per strobe assertion
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= mhbsd_pkg::MHBSD_IDLE;
         wait_cnt_reg <= 2'h0;
      end else begin
         case (state_reg)
            mhbsd_pkg::MHBSD_IDLE: begin
               if (cycle_on) begin
                  state_reg    <= mhbsd_pkg::MHBSD_BUSY;
                  wait_cnt_reg <= mhbsd_pkg::MHBSD_WAIT_CYCLES;
               end
            end
            mhbsd_pkg::MHBSD_BUSY: begin
               if (wait_cnt_reg == 2'h1) begin
                  state_reg <= mhbsd_pkg::MHBSD_DONE;
               end
               wait_cnt_reg <= wait_cnt_reg - 2'h1;
            end
            mhbsd_pkg::MHBSD_DONE: begin
               // hold until strobes go away so one strobe makes one request
               if (!cycle_on) begin
                  state_reg <= mhbsd_pkg::MHBSD_IDLE;
               end
            end
            default: begin
               state_reg <= mhbsd_pkg::MHBSD_IDLE;
            end
         endcase
      end
   end

   // request outputs: one-cycle pulse, fields latched at acceptance
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_valid_reg  <= 1'b0;
         req_write_reg  <= 1'b0;
         req_memory_reg <= 1'b0;
         req_lanes_reg  <= 2'h0;
         req_size_reg   <= 2'h0;
      end else begin
         req_valid_reg <= (state_reg == mhbsd_pkg::MHBSD_IDLE) && cycle_on;
         if ((state_reg == mhbsd_pkg::MHBSD_IDLE) && cycle_on) begin
            req_write_reg  <= act_wr;
            req_memory_reg <= mr_s;
            req_lanes_reg  <= act_lanes;
            req_size_reg   <= act_size;
         end
      end
   end

   // wait pin: active while busy, inactive for the done cycle, then released
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_out_reg  <= 1'b0;
         wait_oe_n_reg <= 1'b1;
      end else begin
         case (state_reg)
            mhbsd_pkg::MHBSD_BUSY: begin
               wait_oe_n_reg <= 1'b0;
               wait_out_reg  <= (wait_cnt_reg == 2'h1) ? !wait_pol_reg : wait_pol_reg;
            end
            mhbsd_pkg::MHBSD_IDLE: begin
               wait_oe_n_reg <= !cycle_on;
               wait_out_reg  <= wait_pol_reg;
            end
            default: begin
               wait_oe_n_reg <= 1'b1;
               wait_out_reg  <= !wait_pol_reg;
            end
         endcase
      end
   end
endmodule

// File: verif/mhbsd_chk_sva.sv
// port assertions for the host bus strobe decoder
`timescale 1ns/100ps
module mhbsd_chk (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic [2:0] mode_strap,
   input wire logic       wait_pol_strap,
   input wire logic       chip_select_n,
   input wire logic       space_select,
   input wire logic       direction_pin,
   input wire logic       req_valid_reg,
   input wire logic       req_write_reg,
   input wire logic       req_memory_reg,
   input wire logic [1:0] req_lanes_reg,
   input wire logic       wait_out_reg,
   input wire logic       wait_oe_n_reg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] mode_seen;
   logic       pol_seen;
   logic       straps_seen;

   // straps as the decoder holds them: caught on the first edge after release
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         straps_seen <= 1'b0;
         mode_seen   <= 3'h7; // no mode checks until the straps are caught
         pol_seen    <= 1'b0;
      end else if (!straps_seen) begin
         straps_seen <= 1'b1;
         mode_seen   <= mode_strap;
         pol_seen    <= wait_pol_strap;
      end
   end

   // pins pass two sync flops plus one decode edge, so causes sit 3 edges back
   a_single_req: assert property (req_valid_reg |=> !req_valid_reg [*4])
      else $error("request repeated");
   a_wait_seq: assert property (req_valid_reg |->
      (wait_out_reg == pol_seen && !wait_oe_n_reg) [*2] ##1
      (wait_out_reg != pol_seen && !wait_oe_n_reg) ##1 wait_oe_n_reg)
      else $error("wait sequence wrong");
   a_cs_gate: assert property (req_valid_reg |-> !$past(chip_select_n, 3))
      else $error("request without chip select");
   a_space_sel: assert property (req_valid_reg |-> req_memory_reg == $past(space_select, 3))
      else $error("space select wrong");
   a_lanes_set: assert property (req_valid_reg |-> req_lanes_reg != 2'h0)
      else $error("request with no lane");
   a_oe_dir: assert property (req_valid_reg && mode_seen == mhbsd_pkg::MHBSD_BYTE_LANE_OE
      |-> req_write_reg == !$past(direction_pin, 3))
      else $error("direction decode wrong");
   a_split_rd: assert property (req_valid_reg && !req_write_reg &&
      mode_seen == mhbsd_pkg::MHBSD_GENERIC_SPLIT |-> req_lanes_reg[1] == !$past(direction_pin, 3))
      else $error("upper read lane wrong");
   a_reset_quiet: assert property ($rose(rst_n) |-> !req_valid_reg && wait_oe_n_reg)
      else $error("outputs active after reset");
endmodule

// File: verif/mhbsd_host.sv
// host processor model driving the strobe pins
`timescale 1ns/100ps
module mhbsd_host (
   input  wire logic       ref_clk,
   input  wire logic       wait_oe_n_reg,
   output logic      [7:0] host_pins
);
   // idle: deselected, strobes off, space select and address bit 0 low
   localparam logic [7:0] IDLE = 8'hbe;
   initial host_pins = IDLE;
   // hold the cycle until the wait pin is released, bounded for refusals
   task automatic access(input logic [7:0] v);
      logic lo;
      lo = 1'b0;
      @(posedge ref_clk) host_pins <= v;
      for (int i = 0; i < 12; i++) begin
         @(posedge ref_clk);
         if (!wait_oe_n_reg) lo = 1'b1;
         else if (lo) break;
      end
      host_pins <= IDLE; // idle long enough for the decoder to rearm
      repeat (6) @(posedge ref_clk);
   endtask
endmodule

// File: verif/tb.sv
// self-checking bench for the host bus strobe decoder
`timescale 1ns/100ps
module tb;
   logic        ref_clk    = 1'b0;
   logic        rst_n      = 1'b0;
   logic [2:0]  mode_strap = 3'h0;
   logic        wait_pol   = 1'b1;
   logic [7:0]  n_act      = 8'h0;
   logic [7:0]  hp;
   logic        req_valid_reg, req_write_reg, req_memory_reg, wait_out_reg, wait_oe_n_reg;
   logic [1:0]  req_lanes_reg, req_size_reg;
   logic [1:0]  n_req = 2'h0;
   logic [5:0]  flds;
   int          n_fail = 0, n_checks = 0, cyc = 0;
   // mode, pins {cs_n,sel,start,dir,rd,wr0,wr1,a0}, expected {count,wr,mem,lanes,size}
   logic [18:0] tab [16] = '{{3'h0,8'h7a,8'h74},{3'h0,8'h2e,8'h48},{3'h1,8'h38,8'h6c},{3'h1,8'h36,8'h44},
      {3'h2,8'h56,8'h5c},{3'h2,8'h4c,8'h78},{3'h3,8'h0c,8'h6c},{3'h3,8'h1d,8'h48},{3'h4,8'h15,8'h49},
      {3'h4,8'h08,8'h6e},{3'h5,8'h2a,8'h64},{3'h5,8'h30,8'h4c},{3'h6,8'h36,8'h4c},{3'h6,8'h3c,8'h68},
      {3'h0,8'h3c,8'h68},{3'h0,8'h36,8'h44}};

   always #10 ref_clk = ~ref_clk;

   mhbsd_host mhbsd_host_inst (.ref_clk, .wait_oe_n_reg, .host_pins(hp));
   mhbsd_top mhbsd_top_inst (.ref_clk, .rst_n, .mode_strap, .wait_pol_strap(wait_pol),
      .chip_select_n(hp[7]), .space_select(hp[6]), .bus_start_pin(hp[5]), .direction_pin(hp[4]),
      .read_strobe_pin(hp[3]), .first_write_strobe_pin(hp[2]), .second_write_strobe_pin(hp[1]),
      .address_bit0_pin(hp[0]), .req_valid_reg, .req_write_reg, .req_memory_reg, .req_lanes_reg,
      .req_size_reg, .wait_out_reg, .wait_oe_n_reg);

   // capture requests; cycle ceiling cuts a hang short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      // driven cycles with the wait pin at its active level
      if (wait_oe_n_reg === 1'b0 && wait_out_reg === wait_pol) n_act <= n_act + 8'h1;
      if (req_valid_reg === 1'b1) begin
         n_req <= n_req + 2'h1;
         flds  <= {req_write_reg, req_memory_reg, req_lanes_reg, req_size_reg};
      end
      if (cyc == 3000) begin
         n_fail++;
         results();
      end
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // reset with a strap value; straps are only caught on release
   task automatic start(input logic [2:0] m);
      @(posedge ref_clk);
      mode_strap <= m;
      rst_n      <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask

   // one host cycle; fields only count when a request is expected
   task automatic xfer(input logic [7:0] v, input logic [7:0] e);
      logic [1:0] n0;
      n0 = n_req; // count by difference so only the capture block writes n_req
      mhbsd_host_inst.access(v);
      check({n_req - n0, (e[7:6] == 2'h0) ? 6'h0 : flds}, e);
   endtask

   task automatic t_modes();
      for (int k = 0; k < 16; k++) begin
         start(tab[k][18:16]);
         xfer(tab[k][15:8], tab[k][7:0]);
      end
      $display("modes test done");
   endtask

   task automatic t_refuse();
      start(3'h0);
      xfer(8'hfa, 8'h00);
      start(3'h7);
      xfer(8'h7a, 8'h00);
      $display("refusal test done");
   endtask

   // strap moved after reset: the latched mode keeps decoding
   task automatic t_latch();
      start(3'h0);
      @(posedge ref_clk) mode_strap <= 3'h1;
      xfer(8'h2e, 8'h48);
      $display("latch test done");
   endtask

   // reset lands just as the request would issue
   task automatic t_reset();
      start(3'h0);
      fork
         mhbsd_host_inst.access(8'h7a);
         begin
            repeat (4) @(posedge ref_clk);
            rst_n <= 1'b0;
            @(posedge ref_clk);
            #1 check({req_valid_reg, wait_oe_n_reg, wait_out_reg, 5'h0}, 8'h40);
         end
      join
      rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      xfer(8'h2e, 8'h48);
      $display("reset test done");
   endtask

   // active-low wait: polarity strap caught with the mode, active for the set count
   task automatic t_pol();
      logic [7:0] n0;
      @(posedge ref_clk) wait_pol <= 1'b0;
      start(3'h5);
      n0 = n_act;
      xfer(8'h2a, 8'h64);
      check(n_act - n0, 8'(mhbsd_pkg::MHBSD_WAIT_CYCLES));
      $display("polarity test done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_modes();
      t_refuse();
      t_latch();
      t_reset();
      t_pol();
      results();
   end
endmodule

bind mhbsd_top mhbsd_chk mhbsd_chk_inst (.ref_clk, .rst_n, .mode_strap, .wait_pol_strap, .chip_select_n,
   .space_select, .direction_pin, .req_valid_reg, .req_write_reg, .req_memory_reg, .req_lanes_reg,
   .wait_out_reg, .wait_oe_n_reg);
